// *** src/spa_pkg.sv ***
// Constants for the shared pin output arbiter: pin indices, modes and option limits
package spa_pkg;
    // Number of single shared pins handled bit by bit
    localparam int NUM_PINS = 19;
    // Width of the memory data upper half reused as host address inputs
    localparam int MEM_HALF_W = 16;

    // Pin indices: first sharer listed first, lower sharers after it
    localparam int PIN_A_SLAVE_OUT = 0;   // serial_port_a_slave_out / two_wire_a_data
    localparam int PIN_A_CLOCK     = 1;   // serial_port_a_clock_pin / two_wire_a_clock
    localparam int PIN_A_CS        = 2;   // serial_port_a_chip_select / two_wire_b_clock
    localparam int PIN_A_ENABLE    = 3;   // serial_port_a_enable_pin / two_wire_b_data
    localparam int PIN_B_CS        = 4;   // audio_port0_data_pins[5] / serial_port_b_chip_select
    localparam int PIN_B_ENABLE    = 5;   // audio_port0_data_pins[6] / serial_port_b_enable_pin
    localparam int PIN_B_CLOCK     = 6;   // audio_port0_data_pins[7] / serial_port_b_clock_pin
    localparam int PIN_B_SLAVE_OUT = 7;   // audio0[8] / audio1[5] / serial_port_b_slave_out
    localparam int PIN_B_SLAVE_IN  = 8;   // audio0[9] / audio1[4] / serial_port_b_slave_in
    localparam int PIN_RX_HCLK     = 15;  // audio0_rx_high_clock / audio1_rx_high_clock
    localparam int PIN_TX_HCLK     = 16;  // audio0_tx_high_clock / audio2_tx_high_clock
    localparam int PIN_MUTE_HOST_INTERRUPT_OUT   = 17;  // audio2_mute_out / host_interrupt_out
    localparam int PIN_HD16        = 18;  // host_data_bit16 / host_halfword_select

    // Second serial port pin options, one to five
    localparam logic [2:0] SB_OPT_FIVE_PIN = 3'h0;  // All five pins
    localparam logic [2:0] SB_OPT_NO_EN    = 3'h1;  // Four pins, no enable
    localparam logic [2:0] SB_OPT_NO_CS    = 3'h2;  // Four pins, no chip select
    localparam logic [2:0] SB_OPT_THREE    = 3'h3;  // Clock and data only
    localparam logic [2:0] SB_OPT_OFF      = 3'h4;  // Port disabled

    // Claim masks in order {slave_in, slave_out, clock, enable, chip_select}
    localparam logic [4:0] SB_CLAIM_FIVE  = 5'h1f;
    localparam logic [4:0] SB_CLAIM_NO_EN = 5'h1d;
    localparam logic [4:0] SB_CLAIM_NO_CS = 5'h1e;
    localparam logic [4:0] SB_CLAIM_THREE = 5'h1c;
    localparam logic [4:0] SB_CLAIM_OFF   = 5'h00;

    // Audio port data pin limits per option
    localparam logic [4:0] A0_MAX_OPT1 = 5'h0b;
    localparam logic [4:0] A0_MAX_OPT2 = 5'h0c;
    localparam logic [4:0] A0_MAX_OPT3 = 5'h0c;
    localparam logic [4:0] A0_MAX_OPT4 = 5'h0d;
    localparam logic [4:0] A0_MAX_OPT5 = 5'h10;
    localparam logic [2:0] A1_MAX_SPI  = 3'h4;
    localparam logic [2:0] A1_MAX_OFF  = 3'h6;
endpackage

// *** src/spa_shared_pin_arbiter.sv ***
// Shared pin output arbiter: per-pin direction, priority and input fan-out
// Summary of operation
// RULE1 - Any sharer driving makes pin output
// RULE2 - Highest priority driver sets pin value
// RULE3 - Software should enable one driver only
// RULE4 - Pin input reaches all sharers together
// RULE5 - Ownership decided per pin, not globally
// RULE6 - Fixed per-pin priority order among peripherals
// RULE7 - Non-multiplexed select releases memory upper half
// RULE8 - Software sets select before memory init
// RULE9 - Memory interface parks driving between accesses
// RULE10 - Host mode pairs with memory bus width
// RULE11 - Second serial port mode claims its pins
// RULE12 - Audio data pin limits follow option
// RULE13 - Host config gives enable and select
// RULE14 - Unclaimed pin stays undriven, input only
module spa_shared_pin_arbiter #(
    parameter int N    = spa_pkg::NUM_PINS,
    parameter int MEMW = spa_pkg::MEM_HALF_W
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    // First priority sharer of each pin
    input  wire logic [N-1:0]    prio1_out,
    input  wire logic [N-1:0]    prio1_oe,
    // Second priority sharer of each pin
    input  wire logic [N-1:0]    prio2_out,
    input  wire logic [N-1:0]    prio2_oe,
    // Third priority sharer, present only on the two serial b data pins
    input  wire logic [N-1:0]    prio3_out,
    input  wire logic [N-1:0]    prio3_oe,
    // Synchronised pin level, common to every sharer
    output logic [N-1:0]         shared_in,
    // Package pins
    input  wire logic [N-1:0]    pin_in,
    output logic [N-1:0]         pin_out,
    output logic [N-1:0]         pin_oe,
    // Second serial port pin option
    input  wire logic [2:0]      serial_b_mode,
    output logic [4:0]           audio0_max_pins,
    output logic [2:0]           audio1_max_pins,
    // Host port configuration bits
    input  wire logic            host_port_enable,
    input  wire logic            host_nonmultiplexed_select,
    output logic                 host_address_valid,
    output logic                 memory_bus_wide,
    // Memory interface upper data half
    input  wire logic [MEMW-1:0] memory_data_out,
    input  wire logic            memory_data_oe,
    output logic [MEMW-1:0]      memory_data_upper_half,
    output logic [MEMW-1:0]      host_address_inputs,
    // Memory upper data pins
    input  wire logic [MEMW-1:0] mem_pin_in,
    output logic [MEMW-1:0]      mem_pin_out,
    output logic [MEMW-1:0]      mem_pin_oe
);
    // Pin synchronisers; first stage feeds only the second
    logic [N-1:0]    pin_meta;
    logic [MEMW-1:0] mem_meta;
    logic [MEMW-1:0] mem_sync;
    // Registered pin drive and derived status
    logic [N-1:0]    next_pin_out;
    logic [N-1:0]    next_pin_oe;
    logic [MEMW-1:0] next_mem_out;
    logic [MEMW-1:0] next_mem_oe;
    logic [4:0]      next_a0_max;
    logic [2:0]      next_a1_max;
    logic [4:0]      sb_claim;     // Pins the serial b option lets it use
    logic [N-1:0]    gate2;        // Second sharer allowed to drive
    logic [N-1:0]    gate3;        // Third sharer exists and is allowed
    logic [N-1:0]    eff2_oe;
    logic [N-1:0]    eff3_oe;

    // Serial b claims and audio limits from the selected option
    always_comb begin
        case (serial_b_mode)
            spa_pkg::SB_OPT_FIVE_PIN: begin
                sb_claim    = spa_pkg::SB_CLAIM_FIVE; // RULE11
                next_a0_max = spa_pkg::A0_MAX_OPT1;   // RULE12
                next_a1_max = spa_pkg::A1_MAX_SPI;
            end
            spa_pkg::SB_OPT_NO_EN: begin
                sb_claim    = spa_pkg::SB_CLAIM_NO_EN; // RULE11
                next_a0_max = spa_pkg::A0_MAX_OPT2;    // RULE12
                next_a1_max = spa_pkg::A1_MAX_SPI;
            end
            spa_pkg::SB_OPT_NO_CS: begin
                sb_claim    = spa_pkg::SB_CLAIM_NO_CS; // RULE11
                next_a0_max = spa_pkg::A0_MAX_OPT3;    // RULE12
                next_a1_max = spa_pkg::A1_MAX_SPI;
            end
            spa_pkg::SB_OPT_THREE: begin
                sb_claim    = spa_pkg::SB_CLAIM_THREE; // RULE11
                next_a0_max = spa_pkg::A0_MAX_OPT4;    // RULE12
                next_a1_max = spa_pkg::A1_MAX_SPI;
            end
            default: begin
                // Disabled or unknown code: all five pins go back to audio
                sb_claim    = spa_pkg::SB_CLAIM_OFF;  // RULE11
                next_a0_max = spa_pkg::A0_MAX_OPT5;   // RULE12
                next_a1_max = spa_pkg::A1_MAX_OFF;
            end
        endcase
    end

    // Which lower sharers may drive; serial b is gated by its option
    always_comb begin
        gate2 = '1;
        gate3 = '0;
        gate2[spa_pkg::PIN_B_CS]        = sb_claim[0];
        gate2[spa_pkg::PIN_B_ENABLE]    = sb_claim[1];
        gate2[spa_pkg::PIN_B_CLOCK]     = sb_claim[2];
        gate3[spa_pkg::PIN_B_SLAVE_OUT] = sb_claim[3];
        gate3[spa_pkg::PIN_B_SLAVE_IN]  = sb_claim[4];
        eff2_oe = prio2_oe & gate2;
        eff3_oe = prio3_oe & gate3;
    end

    // Per-pin direction and value; each pin decides on its own drivers
    always_comb begin
        for (int i = 0; i < N; i++) begin
            // Output if any sharer allowed to drive asks; idle pins float as inputs
            next_pin_oe[i] = prio1_oe[i] | eff2_oe[i] | eff3_oe[i]; // RULE1 RULE5 RULE14
            // Fixed order: first sharer, then second, then third
            if (prio1_oe[i]) begin
                next_pin_out[i] = prio1_out[i]; // RULE2 RULE6
            end else if (eff2_oe[i]) begin
                next_pin_out[i] = prio2_out[i]; // RULE2 RULE6
            end else if (eff3_oe[i]) begin
                next_pin_out[i] = prio3_out[i]; // RULE2
            end else begin
                next_pin_out[i] = 1'b0;
            end
        end
    end

    // Memory upper half: parked drive passes through unless the host owns the lines
    always_comb begin
        // Release wins over parking, so a late select still cuts the drive
        next_mem_oe  = (memory_data_oe && !host_nonmultiplexed_select) ? '1 : '0; // RULE7 RULE9
        next_mem_out = memory_data_out;
    end

    // Register everything; pins leave straight from flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_meta               <= '0;
            shared_in              <= '0;
            mem_meta               <= '0;
            mem_sync               <= '0;
            memory_data_upper_half <= '0;
            host_address_inputs    <= '0;
            pin_out                <= '0;
            pin_oe                 <= '0;
            mem_pin_out            <= '0;
            mem_pin_oe             <= '0;
            audio0_max_pins        <= spa_pkg::A0_MAX_OPT5;
            audio1_max_pins        <= spa_pkg::A1_MAX_OFF;
            host_address_valid     <= 1'b0;
            memory_bus_wide        <= 1'b1;
        end else begin
            pin_meta               <= pin_in;
            shared_in              <= pin_meta;  // RULE4
            mem_meta               <= mem_pin_in;
            mem_sync               <= mem_meta;
            // Both functions see the same synchronised lines
            memory_data_upper_half <= mem_sync;
            host_address_inputs    <= mem_sync;  // RULE7
            pin_out                <= next_pin_out;
            pin_oe                 <= next_pin_oe;
            mem_pin_out            <= next_mem_out;
            mem_pin_oe             <= next_mem_oe;
            audio0_max_pins        <= next_a0_max;
            audio1_max_pins        <= next_a1_max;
            host_address_valid     <= host_port_enable & host_nonmultiplexed_select; // RULE13
            memory_bus_wide        <= !host_nonmultiplexed_select;                   // RULE10
        end
    end

    // Two-stage input path seen at the sharers
    sequence s_pin_seen;
        1'b1 ##2 (shared_in == $past(pin_in, 2));
    endsequence

    chk_output_claim: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE1
        1'b1 |=> ((pin_oe & $past(prio1_oe | eff2_oe | eff3_oe))
                  == $past(prio1_oe | eff2_oe | eff3_oe)))
        else $error("requested pin not turned to output");
    chk_first_wins: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
        1'b1 |=> (((pin_out ^ $past(prio1_out)) & $past(prio1_oe)) == '0))
        else $error("first priority sharer lost the pin");
    chk_second_next: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
        1'b1 |=> (((pin_out ^ $past(prio2_out)) & $past(eff2_oe & ~prio1_oe)) == '0))
        else $error("second sharer value not used");
    chk_idle_float: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
        1'b1 |=> ((pin_oe & ~$past(prio1_oe | prio2_oe | prio3_oe)) == '0))
        else $error("pin driven with no requester");
    chk_input_fanout: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
        !sys_rst [*2] |-> s_pin_seen)
        else $error("pin level not passed to sharers");
    chk_mem_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE7
        host_nonmultiplexed_select |=> (mem_pin_oe == '0))
        else $error("memory upper half still driven");
    chk_mem_parking: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
        (memory_data_oe && !host_nonmultiplexed_select)
        |=> (mem_pin_oe == '1) && (mem_pin_out == $past(memory_data_out)))
        else $error("parked memory drive lost");
    chk_bus_width: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
        1'b1 |=> (memory_bus_wide == !$past(host_nonmultiplexed_select)))
        else $error("memory width option wrong");
    chk_serial_off: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
        (serial_b_mode == spa_pkg::SB_OPT_OFF)
        |=> (pin_oe[spa_pkg::PIN_B_CLOCK] == $past(prio1_oe[spa_pkg::PIN_B_CLOCK])))
        else $error("disabled serial b still drives clock pin");
    chk_audio_limit: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
        (serial_b_mode == spa_pkg::SB_OPT_FIVE_PIN)
        |=> (audio0_max_pins == spa_pkg::A0_MAX_OPT1) && (audio1_max_pins == spa_pkg::A1_MAX_SPI))
        else $error("audio pin limit wrong for five-pin option");
endmodule

// *** verif/spa_pin_model.sv ***
// Package pin model: external drivers and floating lines beyond the pins
module spa_pin_model #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         core_clk,
    // Drive from the device
    input  wire logic [W-1:0] dev_out,
    input  wire logic [W-1:0] dev_oe,
    // Drive from the board
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_oe,
    // Level seen on each line
    output logic [W-1:0]      level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] drift = '0;  // Released lines toggle, so a stale value never passes
    // Remember the inverse of the last level for floating lines
    always_ff @(posedge core_clk) begin
        drift <= ~level;
    end
    // Device drive first, board drive next, else the wandering level
    // An enable not yet set up before the first reset edge counts as released,
    // so a floating line never stays unknown through the whole run
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (dev_oe[i] === 1'b1) begin
                level[i] = dev_out[i];
            end else if (ext_oe[i] === 1'b1) begin
                level[i] = ext_val[i];
            end else begin
                level[i] = drift[i];
            end
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Testbench for the shared pin output arbiter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and counters
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    int          fails, comparisons;
    // Sharer requests and pin lines
    logic [18:0] p1o = '0, p1e = '0, p2o = '0, p2e = '0, p3o = '0, p3e = '0;
    logic [18:0] shared_in, pin_in, pin_out, pin_oe, ext_val = '0, ext_oe = '0;
    // Modes and status
    logic [2:0]  mode = 3'h4;
    logic [4:0]  a0max;
    logic [2:0]  a1max;
    logic        hen = 1'b0, hsel = 1'b0, hav, wide, md_oe = 1'b0;
    // Memory upper half
    logic [15:0] md_out = '0, mduh, hai, mpin_in, mpin_out, mpin_oe;
    logic [15:0] mext_val = '0, mext_oe = '0;
    logic [4:0]  claims [5] = '{spa_pkg::SB_CLAIM_FIVE, spa_pkg::SB_CLAIM_NO_EN,
        spa_pkg::SB_CLAIM_NO_CS, spa_pkg::SB_CLAIM_THREE, spa_pkg::SB_CLAIM_OFF};
    logic [4:0]  a0tab [5] = '{spa_pkg::A0_MAX_OPT1, spa_pkg::A0_MAX_OPT2,
        spa_pkg::A0_MAX_OPT3, spa_pkg::A0_MAX_OPT4, spa_pkg::A0_MAX_OPT5};
    int          k;
    spa_shared_pin_arbiter i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .prio1_out(p1o), .prio1_oe(p1e), .prio2_out(p2o), .prio2_oe(p2e),
        .prio3_out(p3o), .prio3_oe(p3e), .shared_in(shared_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .serial_b_mode(mode),
        .audio0_max_pins(a0max), .audio1_max_pins(a1max), .host_port_enable(hen),
        .host_nonmultiplexed_select(hsel), .host_address_valid(hav),
        .memory_bus_wide(wide), .memory_data_out(md_out), .memory_data_oe(md_oe),
        .memory_data_upper_half(mduh), .host_address_inputs(hai),
        .mem_pin_in(mpin_in), .mem_pin_out(mpin_out), .mem_pin_oe(mpin_oe));
    spa_pin_model #(.W(19)) i_pins (.core_clk(core_clk), .dev_out(pin_out),
        .dev_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe), .level(pin_in));
    spa_pin_model #(.W(16)) i_mem (.core_clk(core_clk), .dev_out(mpin_out),
        .dev_oe(mpin_oe), .ext_val(mext_val), .ext_oe(mext_oe), .level(mpin_in));
    // Free running clock, 20 ns period
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // Compare one result; an unknown never matches
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Values held while reset is applied
    task automatic check_reset();
        chk("pin_oe", 0, pin_oe);
        chk("mem_pin_oe", 0, mpin_oe);
        chk("audio0_max", spa_pkg::A0_MAX_OPT5, a0max);
        chk("audio1_max", spa_pkg::A1_MAX_OFF, a1max);
        chk("bus_wide", 1, wide);
        chk("addr_valid", 0, hav);
    endtask
    // Apply drive requests, then compare after one registered cycle
    task automatic drive(logic [18:0] e1, v1, e2, v2, e3, exp_oe, exp_out);
        p1e = e1;
        p1o = v1;
        p2e = e2;
        p2o = v2;
        p3e = e3;
        p3o = '1;
        @(negedge core_clk);
        chk("pin_oe", exp_oe, pin_oe);
        chk("pin_out", exp_out & exp_oe, pin_out & pin_oe);
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        check_reset();
        sys_rst = 1'b0;
        mode = 3'h0;
        // Higher sharer wins, lower alone drives, nobody leaves the pin floating
        drive('1, 19'h2aaaa, '1, 19'h55555, 0, '1, 19'h2aaaa);
        drive(0, 0, '1, 19'h55555, 0, '1, 19'h55555);
        drive(19'h0f0f0, 0, '1, '1, 0, '1, ~19'h0f0f0);
        drive(0, 0, 0, 0, 19'h180, 19'h180, 19'h180);
        drive(0, 0, 19'h180, 0, 19'h180, 19'h180, 0);
        drive(0, 0, 0, 0, 0, 0, 0);
        // Second serial port options claim only their own pins
        for (k = 0; k < 6; k++) begin
            mode = 3'(k);
            drive(0, 0, 19'h070, '1, 19'h180, {10'h0, claims[k > 4 ? 4 : k], 4'h0}, '1);
            chk("audio0_max", a0tab[k > 4 ? 4 : k], a0max);
            chk("audio1_max", k < 4 ? spa_pkg::A1_MAX_SPI : spa_pkg::A1_MAX_OFF, a1max);
        end
        // Only the board drives; every sharer sees the same level
        ext_oe = '1;
        for (k = 0; k < 2; k++) begin
            ext_val = k ? 19'h52c3a : 19'h2d3c5;
            repeat (4) @(negedge core_clk);
            chk("shared_in", ext_val, shared_in);
        end
        // Memory interface parks on the upper half in multiplexed mode
        hen = 1'b1;
        md_oe = 1'b1;
        md_out = 16'hc3a5;
        @(negedge core_clk);
        md_out = 16'h5a3c;
        chk("mem_pin_oe", 16'hffff, mpin_oe);
        chk("mem_pin_out", 16'hc3a5, mpin_out);
        chk("bus_wide", 1, wide);
        @(negedge core_clk);
        chk("mem_pin_out", 16'h5a3c, mpin_out);
        // Select set before the board drives host address lines
        hsel = 1'b1;
        @(negedge core_clk);
        chk("mem_pin_oe", 0, mpin_oe);
        chk("bus_wide", 0, wide);
        chk("addr_valid", 1, hav);
        mext_oe = '1;
        mext_val = 16'h9e61;
        hen = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("host_addr", 16'h9e61, hai);
        chk("mem_upper", 16'h9e61, mduh);
        chk("addr_valid", 0, hav);
        // Second reset in mid-run
        sys_rst = 1'b1;
        p1e = '1;
        repeat (2) @(negedge core_clk);
        check_reset();
        // Release again: held requests take the pins one cycle later
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk("pin_oe", 19'h7ffff, pin_oe);
        chk("pin_out", 0, pin_out);
        chk("bus_wide", 0, wide);
        chk("mem_pin_oe", 0, mpin_oe);
        report_and_stop();
    end
endmodule
